// >>> core/licr_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "licr_defines.svh"

// Summary of operation
// - gain mode bit selects automatic or coded gain
// - bit 7 selects T1 or E1 standard
// - rising interface reset bit pulses datapath reset
// - rising insert bit arms one violation insertion
// - enable bit low sends all ones
// - source bit picks master clock or PLL
// - custom driver gives square or open drain
// - edge bit selects transmit sampling edge
// - edge bit selects receive update edge
// - monitor field selects receive gain boost
// - enable bit selects sync clock receive mode
// - enable bit makes transmitter send sync clock
// - pattern bit sends alternating ones and zeros
// - coding bit switches to CMI coding
// - invert bit inverts CMI line signal
// - prescaler and source must match master clock
// - two bits select transmit termination
// - build-out field in bits 5 to 7
// - two bits select receive termination
module licr_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [`LICR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [`LICR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transmit bit stream from the framer and line clock ticks
  input wire logic tx_bit_valid,
  input wire logic tx_bit,
  input wire logic attenuator_clock_tick,
  input wire logic transmit_line_clock_tick,
  // towards line datapath
  output licr_pkg::licr_cfg_t cfg,
  output licr_pkg::licr_txsrc_t tx_source,
  output logic tx_line_bit,
  output logic tx_line_bit_valid,
  output logic bpv_insert,
  output logic interface_reset_pulse
);
  import licr_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] licr_index(input logic [`LICR_ADDR_W-1:0] a);
    licr_index = a[9:2];
  endfunction

  function automatic logic licr_mapped(input logic [`LICR_ADDR_W-1:0] a);
    logic [7:0] i;
    i = licr_index(a);
    licr_mapped = (a[1:0] == 2'h0) && ((i == `LICR_IDX_LIC1) || (i == `LICR_IDX_LIC2) ||
      (i == `LICR_IDX_LIC3) || (i == `LICR_IDX_LIC4) || (i == `LICR_IDX_GAIN));
  endfunction

  function automatic licr_term_t licr_term(input logic [1:0] c);
    licr_term = licr_term_t'(c);
  endfunction

  function automatic logic [5:0] licr_boost(input logic [1:0] m);
    unique case (m)
      2'h0: licr_boost = 6'h00;
      2'h1: licr_boost = 6'h14;
      2'h2: licr_boost = 6'h1a;
      2'h3: licr_boost = 6'h20;
    endcase
  endfunction

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] lic1_ff;
  logic [7:0] lic2_ff;
  logic [7:0] lic3_ff;
  logic [7:0] lic4_ff;
  logic [7:0] gain_ff;

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  logic aw_held_ff;
  logic w_held_ff;
  logic [`LICR_ADDR_W-1:0] awaddr_ff;
  logic [7:0] wbyte_ff;
  logic wlane_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic aw_take;
  logic w_take;
  logic wr_do;
  logic [`LICR_ADDR_W-1:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic [7:0] wr_idx;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_do = (aw_held_ff || aw_take) && (w_held_ff || w_take) && !bvalid_ff;
  assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
  assign wr_byte = w_held_ff ? wbyte_ff : s_axi_wdata[7:0];
  assign wr_lane = w_held_ff ? wlane_ff : s_axi_wstrb[0];
  assign wr_idx = licr_index(wr_addr);
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'h0;
      awaddr_ff <= '0;
    end else if (wr_do) begin
      aw_held_ff <= 1'h0;
    end else if (aw_take) begin
      aw_held_ff <= 1'h1;
      awaddr_ff <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'h0;
      wbyte_ff <= '0;
      wlane_ff <= 1'h0;
    end else if (wr_do) begin
      w_held_ff <= 1'h0;
    end else if (w_take) begin
      w_held_ff <= 1'h1;
      wbyte_ff <= s_axi_wdata[7:0];
      wlane_ff <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'h0;
      bresp_ff <= `LICR_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_ff <= 1'h1;
      bresp_ff <= licr_mapped(wr_addr) ? `LICR_RESP_OKAY : `LICR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'h0;
    end
  end

  // register updates; only byte lane 0 carries the 8-bit fields
  logic wr_hit;
  assign wr_hit = wr_do && wr_lane && licr_mapped(wr_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lic1_ff <= `LICR_RST_REG;
      lic2_ff <= `LICR_RST_REG;
      lic3_ff <= `LICR_RST_REG;
      lic4_ff <= `LICR_RST_REG;
      gain_ff <= `LICR_RST_REG;
    end else if (wr_hit) begin
      unique case (wr_idx)
        `LICR_IDX_LIC1: lic1_ff <= wr_byte;
        `LICR_IDX_LIC2: lic2_ff <= wr_byte & `LICR_MASK_LIC2;
        `LICR_IDX_LIC3: lic3_ff <= wr_byte & `LICR_MASK_LIC3;
        `LICR_IDX_LIC4: lic4_ff <= wr_byte;
        `LICR_IDX_GAIN: gain_ff <= wr_byte & `LICR_MASK_GAIN;
        default: lic1_ff <= lic1_ff;
      endcase
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  logic rvalid_ff;
  licr_rdat_t rdat_ff;
  licr_rdat_t nxt_rdat;
  logic [7:0] rd_idx;

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdat_ff.data;
  assign s_axi_rresp = rdat_ff.resp;
  assign rd_idx = licr_index(s_axi_araddr);

  always_comb begin
    nxt_rdat.data = 32'h0000_0000;
    nxt_rdat.resp = licr_mapped(s_axi_araddr) ? `LICR_RESP_OKAY : `LICR_RESP_SLVERR;
    if (licr_mapped(s_axi_araddr)) begin
      unique case (rd_idx)
        `LICR_IDX_LIC1: nxt_rdat.data[7:0] = lic1_ff;
        `LICR_IDX_LIC2: nxt_rdat.data[7:0] = lic2_ff;
        `LICR_IDX_LIC3: nxt_rdat.data[7:0] = lic3_ff;
        `LICR_IDX_LIC4: nxt_rdat.data[7:0] = lic4_ff;
        `LICR_IDX_GAIN: nxt_rdat.data[7:0] = gain_ff;
        default: nxt_rdat.data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'h0;
      rdat_ff <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'h1;
      rdat_ff <= nxt_rdat;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'h0;
    end
  end

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  licr_cfg_t cfg_ff;
  licr_cfg_t nxt_cfg;
  logic [2:0] bo;

  assign bo = lic1_ff[`LICR_LIC1_BO_LSB +: 3];
  assign cfg = cfg_ff;

  always_comb begin
    nxt_cfg.line_standard_e1 = lic2_ff[`LICR_LIC2_STD];
    nxt_cfg.attenuator_clock_source = lic2_ff[`LICR_LIC2_JSRC];
    nxt_cfg.prescaler = lic4_ff[`LICR_LIC4_PS_LSB +: 2];
    nxt_cfg.gain_auto = !gain_ff[`LICR_GAIN_MODE];
    nxt_cfg.gain_code = gain_ff[`LICR_GAIN_MODE] ? gain_ff[`LICR_GAIN_CODE_LSB +: 6] : 6'h00;
    nxt_cfg.drv_square_wave = lic2_ff[`LICR_LIC2_CDRV] && (bo == 3'h0);
    nxt_cfg.drv_open_drain = lic2_ff[`LICR_LIC2_CDRV] && (bo != 3'h0);
    nxt_cfg.build_out_field = bo;
    nxt_cfg.tx_sample_rising = lic3_ff[`LICR_LIC3_TEDGE];
    nxt_cfg.rx_update_falling = lic3_ff[`LICR_LIC3_REDGE];
    nxt_cfg.rx_boost_db = licr_boost(lic3_ff[`LICR_LIC3_MM_LSB +: 2]);
    nxt_cfg.rx_sync_clock_mode = lic3_ff[`LICR_LIC3_RSCK];
    nxt_cfg.tx_sync_clock_send = lic3_ff[`LICR_LIC3_TSCK];
    nxt_cfg.coding_enable = lic4_ff[`LICR_LIC4_CODE_EN];
    nxt_cfg.coding_invert = lic4_ff[`LICR_LIC4_CODE_INV];
    nxt_cfg.tx_term = licr_term(lic4_ff[`LICR_LIC4_TT_LSB +: 2]);
    nxt_cfg.rx_term = licr_term(lic4_ff[`LICR_LIC4_RT_LSB +: 2]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // ----------------------------------------
  // interface reset and violation arming
  // ----------------------------------------
  logic lrst_d_ff;
  logic vins_d_ff;
  logic lrst_pulse_ff;
  logic armed_ff;
  logic [1:0] run_ff;
  logic bpv_ff;
  logic fire;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lrst_d_ff <= 1'h0;
      vins_d_ff <= 1'h0;
      lrst_pulse_ff <= 1'h0;
    end else begin
      lrst_d_ff <= lic2_ff[`LICR_LIC2_LRST];
      vins_d_ff <= lic2_ff[`LICR_LIC2_VINS];
      lrst_pulse_ff <= lic2_ff[`LICR_LIC2_LRST] && !lrst_d_ff;
    end
  end

  assign interface_reset_pulse = lrst_pulse_ff;
  assign fire = armed_ff && tx_bit_valid && tx_bit && (run_ff == `LICR_RUN_THIRD);

  // a new arm in the cycle of an insertion wins over the disarm
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_ff <= 1'h0;
    end else if (lic2_ff[`LICR_LIC2_VINS] && !vins_d_ff) begin
      armed_ff <= 1'h1;
    end else if (fire) begin
      armed_ff <= 1'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_ff <= 2'h0;
    end else if (tx_bit_valid) begin
      if (!tx_bit || fire) begin
        run_ff <= 2'h0;
      end else if (run_ff != `LICR_RUN_THIRD) begin
        run_ff <= run_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bpv_ff <= 1'h0;
    end else begin
      bpv_ff <= fire;
    end
  end

  assign bpv_insert = bpv_ff;

  // ----------------------------------------
  // transmit pattern source
  // ----------------------------------------
  licr_txsrc_t src_ff;
  licr_txsrc_t nxt_src;
  logic alt_ff;
  logic tx_out_ff;
  logic tx_out_vld_ff;

  always_comb begin
    if (!lic2_ff[`LICR_LIC2_TXEN]) begin
      nxt_src = LICR_TX_ONES;
    end else if (lic3_ff[`LICR_LIC3_ALT]) begin
      nxt_src = LICR_TX_ALT;
    end else begin
      nxt_src = LICR_TX_DATA;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_ff <= LICR_TX_ONES;
    end else begin
      src_ff <= nxt_src;
    end
  end

  assign tx_source = src_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alt_ff <= 1'h0;
    end else if (src_ff == LICR_TX_ALT && transmit_line_clock_tick) begin
      alt_ff <= !alt_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_out_ff <= 1'h1;
      tx_out_vld_ff <= 1'h0;
    end else begin
      unique case (src_ff)
        LICR_TX_ONES: begin
          tx_out_ff <= 1'h1;
          tx_out_vld_ff <= attenuator_clock_tick;
        end
        LICR_TX_ALT: begin
          tx_out_ff <= !alt_ff;
          tx_out_vld_ff <= transmit_line_clock_tick;
        end
        default: begin
          tx_out_ff <= tx_bit;
          tx_out_vld_ff <= tx_bit_valid;
        end
      endcase
    end
  end

  assign tx_line_bit = tx_out_ff;
  assign tx_line_bit_valid = tx_out_vld_ff;

endmodule
`default_nettype wire

// >>> core/licr_defines.svh
`ifndef LICR_DEFINES_SVH
`define LICR_DEFINES_SVH
// ----------------------------------------
// register indices and address width
// ----------------------------------------
`define LICR_IDX_LIC1 8'h78
`define LICR_IDX_LIC2 8'h79
`define LICR_IDX_LIC3 8'h7a
`define LICR_IDX_LIC4 8'h7b
`define LICR_IDX_GAIN 8'h7d
`define LICR_ADDR_W 10
// ----------------------------------------
// reset values
// ----------------------------------------
`define LICR_RST_REG 8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define LICR_LIC1_BO_LSB 5
`define LICR_LIC2_STD 7
`define LICR_LIC2_LRST 6
`define LICR_LIC2_VINS 5
`define LICR_LIC2_TXEN 4
`define LICR_LIC2_JSRC 3
`define LICR_LIC2_CDRV 0
`define LICR_LIC3_TEDGE 6
`define LICR_LIC3_REDGE 5
`define LICR_LIC3_MM_LSB 3
`define LICR_LIC3_RSCK 2
`define LICR_LIC3_TSCK 1
`define LICR_LIC3_ALT 0
`define LICR_LIC4_CODE_EN 7
`define LICR_LIC4_CODE_INV 6
`define LICR_LIC4_PS_LSB 4
`define LICR_LIC4_TT_LSB 2
`define LICR_LIC4_RT_LSB 0
`define LICR_GAIN_MODE 6
`define LICR_GAIN_CODE_LSB 0
// ----------------------------------------
// write masks, bus answers and run limit
// ----------------------------------------
`define LICR_MASK_LIC2 8'hfb
`define LICR_MASK_LIC3 8'h7f
`define LICR_MASK_GAIN 8'h7f
`define LICR_RESP_OKAY 2'h0
`define LICR_RESP_SLVERR 2'h2
`define LICR_RUN_THIRD 2'h2
`endif

// >>> core/licr_pkg.sv
`default_nettype none
package licr_pkg;
  typedef enum logic [1:0] {LICR_TERM_OFF, LICR_TERM_75, LICR_TERM_100, LICR_TERM_120} licr_term_t;
  typedef enum logic [1:0] {LICR_TX_DATA, LICR_TX_ONES, LICR_TX_ALT} licr_txsrc_t;
  typedef struct packed {
    logic line_standard_e1;
    logic attenuator_clock_source;
    logic [1:0] prescaler;
    logic gain_auto;
    logic [5:0] gain_code;
    logic drv_square_wave;
    logic drv_open_drain;
    logic [2:0] build_out_field;
    logic tx_sample_rising;
    logic rx_update_falling;
    logic [5:0] rx_boost_db;
    logic rx_sync_clock_mode;
    logic tx_sync_clock_send;
    logic coding_enable;
    logic coding_invert;
    licr_term_t tx_term;
    licr_term_t rx_term;
  } licr_cfg_t;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } licr_rdat_t;
endpackage
`default_nettype wire

// >>> dv/licr_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module licr_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // line side
  input wire logic tx_bit_valid,
  input wire logic tx_bit,
  input wire licr_pkg::licr_cfg_t cfg,
  input wire licr_pkg::licr_txsrc_t tx_source,
  input wire logic tx_line_bit,
  input wire logic tx_line_bit_valid,
  input wire logic bpv_insert,
  input wire logic interface_reset_pulse
);
  import licr_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // bus and field checks
  // ----------------------------------------
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rans: assert property (p_rans) else $error("read not answered");
  property p_bblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_bblk: assert property (p_bblk) else $error("write taken while answering");
  property p_rup; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rup: assert property (p_rup) else $error("upper read bytes not zero");
  property p_gain; cfg.gain_auto |-> cfg.gain_code == 6'h00; endproperty
  a_gain: assert property (p_gain) else $error("gain code used in automatic mode");
  property p_drv; cfg.drv_square_wave |-> !cfg.drv_open_drain && cfg.build_out_field == 3'h0; endproperty
  a_drv: assert property (p_drv) else $error("driver mode conflict");
  property p_bst; cfg.rx_boost_db inside {6'h00, 6'h14, 6'h1a, 6'h20}; endproperty
  a_bst: assert property (p_bst) else $error("illegal boost value");
  property p_bpv; bpv_insert |-> $past(tx_bit_valid) && $past(tx_bit) ##1 !bpv_insert; endproperty
  a_bpv: assert property (p_bpv) else $error("violation not on a one or too long");
  property p_lrst; interface_reset_pulse |=> !interface_reset_pulse; endproperty
  a_lrst: assert property (p_lrst) else $error("reset pulse too long");
  property p_ones; tx_line_bit_valid && tx_source == LICR_TX_ONES && $past(tx_source) == LICR_TX_ONES |-> tx_line_bit;
  endproperty
  a_ones: assert property (p_ones) else $error("zero sent in all ones mode");
endmodule
bind licr_top licr_chk u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .tx_bit_valid,
  .tx_bit, .cfg, .tx_source, .tx_line_bit, .tx_line_bit_valid, .bpv_insert, .interface_reset_pulse);
`default_nettype wire

// >>> dv/line_interface_control_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "licr_defines.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; $display("FAIL %0t got %h exp %h", $time, a, e); end end
module line_interface_control_regs_test;
  import licr_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic tx_bit_valid = 1'h0, tx_bit = 1'h0, attenuator_clock_tick = 1'h0, transmit_line_clock_tick = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  licr_cfg_t cfg;
  licr_txsrc_t tx_source;
  logic tx_line_bit, tx_line_bit_valid, bpv_insert, interface_reset_pulse;
  int err_count = 0, compares = 0;
  logic [7:0] bpv_cnt = 8'h0, rst_cnt = 8'h0;
  logic [7:0] idx [5] = '{`LICR_IDX_LIC1, `LICR_IDX_LIC2, `LICR_IDX_LIC3, `LICR_IDX_LIC4, `LICR_IDX_GAIN};
  logic [7:0] msk [5] = '{8'hff, 8'hfb, 8'h7f, 8'hff, 8'h7f};
  logic [5:0] bst [4] = '{6'h00, 6'h14, 6'h1a, 6'h20};
  // recommended manual gain codes, T1 without match, build-out 0 to 3
  logic [5:0] gcode [4] = '{6'h26, 6'h1b, 6'h1a, 6'h20};
  licr_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_bit_valid, .tx_bit,
    .attenuator_clock_tick, .transmit_line_clock_tick, .cfg, .tx_source, .tx_line_bit, .tx_line_bit_valid,
    .bpv_insert, .interface_reset_pulse);
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (aresetn) begin
      bpv_cnt <= bpv_cnt + {7'h0, bpv_insert};
      rst_cnt <= rst_cnt + {7'h0, interface_reset_pulse};
    end
  end
  // ----------------------------------------
  // bus and line tasks
  // ----------------------------------------
  task automatic wr(input logic [9:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    fork
      begin
        do @(negedge aclk); while (!s_axi_awready);
        @(posedge aclk);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(negedge aclk); while (!s_axi_wready);
        @(posedge aclk);
        s_axi_wvalid <= 1'h0;
      end
    join
    // leave the answer waiting one cycle so that its hold is exercised
    @(posedge aclk);
    s_axi_bready <= 1'h1;
    do @(negedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    @(posedge aclk);
    s_axi_rready <= 1'h1;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask
  task automatic wc(input logic [7:0] i, input logic [7:0] d);
    logic [1:0] r;
    wr({i, 2'h0}, d, r);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic sb(input logic b);
    @(posedge aclk);
    tx_bit_valid <= 1'h1;
    tx_bit <= b;
    @(posedge aclk);
    tx_bit_valid <= 1'h0;
    @(negedge aclk);
    `CHK(tx_line_bit_valid, 1'h1)
    `CHK(tx_line_bit, b)
    repeat (2) @(posedge aclk);
  endtask
  task automatic tk(input logic alt, input logic e);
    @(posedge aclk);
    if (alt) transmit_line_clock_tick <= 1'h1;
    else attenuator_clock_tick <= 1'h1;
    @(posedge aclk);
    transmit_line_clock_tick <= 1'h0;
    attenuator_clock_tick <= 1'h0;
    @(negedge aclk);
    `CHK(tx_line_bit_valid, 1'h1)
    `CHK(tx_line_bit, e)
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    `CHK(tx_source, LICR_TX_ONES)
    for (int i = 0; i < 5; i++) begin
      rd({idx[i], 2'h0}, d, r);
      `CHK(d, 32'h0)
      `CHK(r, `LICR_RESP_OKAY)
      wr({idx[i], 2'h0}, 8'hff, r);
      rd({idx[i], 2'h0}, d, r);
      `CHK(d, {24'h0, msk[i]})
    end
    wr(10'h3fc, 8'hff, r);
    `CHK(r, `LICR_RESP_SLVERR)
    rd(10'h3fc, d, r);
    `CHK(r, `LICR_RESP_SLVERR)
    repeat (3) @(posedge aclk);
    `CHK(cfg.line_standard_e1, 1'h1)
    `CHK(cfg.attenuator_clock_source, 1'h1)
    `CHK(cfg.prescaler, 2'h3)
    `CHK(cfg.gain_auto, 1'h0)
    `CHK(cfg.gain_code, 6'h3f)
    `CHK(cfg.drv_open_drain, 1'h1)
    `CHK(cfg.build_out_field, 3'h7)
    `CHK(cfg.tx_sample_rising, 1'h1)
    `CHK(cfg.rx_update_falling, 1'h1)
    `CHK(cfg.rx_sync_clock_mode, 1'h1)
    `CHK(cfg.tx_sync_clock_send, 1'h1)
    `CHK(cfg.coding_enable, 1'h1)
    `CHK(cfg.coding_invert, 1'h1)
    `CHK(tx_source, LICR_TX_ALT)
  endtask
  task automatic t_fields;
    for (int i = 0; i < 4; i++) begin
      wc(`LICR_IDX_LIC1, {i[2:0], 5'h0});
      wc(`LICR_IDX_LIC2, 8'h01);
      wc(`LICR_IDX_LIC3, {3'h0, i[1:0], 3'h0});
      wc(`LICR_IDX_LIC4, {4'h0, i[1:0], i[1:0]});
      wc(`LICR_IDX_GAIN, {1'h0, i[0], gcode[i]});
      `CHK(cfg.rx_boost_db, bst[i])
      `CHK(cfg.tx_term, i[1:0])
      `CHK(cfg.rx_term, i[1:0])
      `CHK(cfg.drv_square_wave, i == 0)
      `CHK(cfg.drv_open_drain, i != 0)
      `CHK(cfg.gain_code, i[0] ? gcode[i] : 6'h00)
      `CHK(cfg.gain_auto, !i[0])
      `CHK({cfg.tx_sample_rising, cfg.rx_update_falling}, 2'h0)
      `CHK({cfg.rx_sync_clock_mode, cfg.tx_sync_clock_send}, 2'h0)
      `CHK({cfg.coding_enable, cfg.coding_invert, cfg.attenuator_clock_source}, 3'h0)
      `CHK(cfg.line_standard_e1, 1'h0)
    end
  endtask
  task automatic t_bpv;
    logic [7:0] b0;
    logic [7:0] r0;
    b0 = bpv_cnt;
    r0 = rst_cnt;
    wc(`LICR_IDX_LIC2, 8'h10);
    `CHK(tx_source, LICR_TX_DATA)
    wc(`LICR_IDX_LIC2, 8'h30);
    sb(1'h1);
    sb(1'h0);
    sb(1'h1);
    sb(1'h1);
    `CHK(bpv_cnt - b0, 0)
    for (int i = 0; i < 3; i++) sb(1'h1);
    `CHK(bpv_cnt - b0, 1)
    wc(`LICR_IDX_LIC2, 8'h10);
    wc(`LICR_IDX_LIC2, 8'h30);
    for (int i = 0; i < 3; i++) sb(1'h1);
    `CHK(bpv_cnt - b0, 2)
    wc(`LICR_IDX_LIC2, 8'h50);
    wc(`LICR_IDX_LIC2, 8'h50);
    `CHK(rst_cnt - r0, 1)
    wc(`LICR_IDX_LIC2, 8'h10);
    wc(`LICR_IDX_LIC2, 8'h50);
    `CHK(rst_cnt - r0, 2)
  endtask
  task automatic t_pat;
    wc(`LICR_IDX_LIC2, 8'h00);
    tk(1'h0, 1'h1);
    tk(1'h0, 1'h1);
    wc(`LICR_IDX_LIC2, 8'h10);
    wc(`LICR_IDX_LIC3, 8'h01);
    `CHK(tx_source, LICR_TX_ALT)
    for (int i = 0; i < 4; i++) tk(1'h1, ~i[0]);
  endtask
  task automatic wrap_up;
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    wrap_up;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_fields;
    t_bpv;
    t_pat;
    wrap_up;
  end
endmodule
`default_nettype wire
